// ==== dpap_pkg.sv ====
// Shared constants of the dual pulse-added PWM block
package dpap_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [15:0] IDX_ROUTE   = 16'hfe57;
  localparam logic [15:0] IDX_ADD_A   = 16'hfe72;
  localparam logic [15:0] IDX_PW_A    = 16'hfe73;
  localparam logic [15:0] IDX_ADD_B   = 16'hfe74;
  localparam logic [15:0] IDX_PW_B    = 16'hfe75;
  localparam logic [15:0] IDX_CTRL    = 16'hfe76;
  localparam logic [15:0] IDX_IRQ_STS = 16'hfe78;
  localparam logic [15:0] IDX_IRQ_MSK = 16'hfe79;
  localparam int          ADDR_W      = 20;

  // Route register fields; absent bits read as one
  localparam int         ROUTE_SEL_BIT = 0;
  localparam int         ROUTE_FIX_BIT = 1;
  localparam int         ROUTE_MON_BIT = 4;
  localparam logic [7:0] ROUTE_ONES    = 8'hec;
  localparam logic [2:0] ROUTE_RESET   = 3'h0;

  // Added-pulse registers: field in 7:4, low nibble reads as ones
  localparam int         ADD_LSB    = 4;
  localparam logic [3:0] ADD_FILL   = 4'hf;
  localparam logic [3:0] ADD_RESET  = 4'h0;
  localparam logic [7:0] PW_RESET   = 8'h00;

  // Control register fields
  localparam int         CTRL_PER_LSB = 4;
  localparam int         CTRL_RUN_B   = 3;
  localparam int         CTRL_RUN_A   = 2;
  localparam int         CTRL_OV      = 1;
  localparam int         CTRL_IE      = 0;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic       IRQ_RESET    = 1'b0;

  // Timebase: one mclk is one third of an instruction cycle
  localparam int         CLK_PERIOD_NS   = 50;
  localparam logic [3:0] UNITS_PER_STEP  = 4'hf; // 16 units, last index
  localparam logic [3:0] STEPS_PER_ALL   = 4'hf; // 16 periods, last index
endpackage

// ==== dpap_chan_if.sv ====
// Timebase and setting bundle between the core and one PWM channel
`timescale 1ns/1ps
interface dpap_chan_if;
  logic [7:0] pos;
  logic       last;
  logic [3:0] idx;
  logic       run;
  logic [7:0] pw;
  logic [3:0] add;
  logic       wave;
  modport src  (output pos, last, idx, run, pw, add, input wave);
  modport chan (input pos, last, idx, run, pw, add, output wave);
endinterface

// ==== dpap_chan.sv ====
// One pulse-added PWM channel: fundamental compare plus added pulse
`timescale 1ns/1ps
module dpap_chan
  import dpap_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Timebase and settings
  dpap_chan_if.chan ch
);
  typedef struct packed {
    logic wave;
  } dpap_chan_st_t;

  dpap_chan_st_t st_q;
  dpap_chan_st_t st_d;
  logic          extra;
  logic [8:0]    thr;

  // Bit reversal spreads the stretched periods evenly over sixteen
  function automatic logic [3:0] dpap_rev4(input logic [3:0] v);
    dpap_rev4 = {v[0], v[1], v[2], v[3]};
  endfunction

  always_comb
  begin
    extra = (dpap_rev4(ch.idx) < ch.add);
    thr   = {1'b0, ch.pw} + {8'h00, extra};
    st_d  = st_q;
    // Last unit always low, so the widest pulse is period minus one unit
    st_d.wave = ch.run && ({1'b0, ch.pos} < thr) && !ch.last;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign ch.wave = st_q.wave;

  AST_LAST_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
    ch.last |=> !ch.wave)
    else $error("wave high in the last unit of a period");
  AST_FUND_WIDTH: assert property (@(posedge mclk) disable iff (!rst_n)
    (ch.run && !ch.last && ch.pos < ch.pw) |=> ch.wave)
    else $error("wave low inside the programmed width");
  AST_PLAIN_MODE: assert property (@(posedge mclk) disable iff (!rst_n)
    (ch.add == 4'h0 && ch.pos >= ch.pw) |=> !ch.wave)
    else $error("wave high past width with no added pulse");
  AST_ADDED: assert property (@(posedge mclk) disable iff (!rst_n)
    (ch.run && !ch.last && ch.pos == ch.pw
      && dpap_rev4(ch.idx) < ch.add) |=> ch.wave)
    else $error("added pulse missing");
endmodule

// ==== dpap_top.sv ====
// Dual pulse-added PWM with APB register access
`timescale 1ns/1ps
module dpap_top
  import dpap_pkg::*;
(
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rstn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [dpap_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Interrupt
  output logic                               irq,
  // Output pin pairs, bit 0 channel a, bit 1 channel b
  output logic      [1:0]                    port2_pwm,
  output logic      [1:0]                    port3_pwm
);
  typedef struct packed {
    logic [2:0]  route;
    logic [3:0]  add_a;
    logic [7:0]  pw_a;
    logic [3:0]  add_b;
    logic [7:0]  pw_b;
    logic [7:0]  ctrl;
    logic        sts;
    logic        msk;
    logic [3:0]  unit;
    logic [3:0]  step;
    logic [3:0]  idx;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        irq;
    logic [1:0]  p2;
    logic [1:0]  p3;
  } dpap_top_st_t;

  dpap_top_st_t st_q;
  dpap_top_st_t st_d;
  logic [1:0]   rst_sync_q;
  logic         rst_n;
  logic         run_any;
  logic         fund_end;
  logic         all_end;
  logic         access;
  logic         wr;
  logic         rd;
  logic         hit;
  logic [7:0]   rval;

  dpap_chan_if ch_a ();
  dpap_chan_if ch_b ();

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] dpap_addr(input logic [15:0] idx);
    dpap_addr = {2'b00, idx, 2'b00};
  endfunction

  // Release of reset is synchronised; assertion stays asynchronous
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  dpap_chan u_chan_a (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ch    (ch_a.chan)
  );
  dpap_chan u_chan_b (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ch    (ch_b.chan)
  );

  // Shared timebase feeds both channels
  assign ch_a.pos  = {st_q.step, st_q.unit};
  assign ch_b.pos  = {st_q.step, st_q.unit};
  assign ch_a.last = fund_end;
  assign ch_b.last = fund_end;
  assign ch_a.idx  = st_q.idx;
  assign ch_b.idx  = st_q.idx;
  assign ch_a.run  = st_q.ctrl[CTRL_RUN_A];
  assign ch_b.run  = st_q.ctrl[CTRL_RUN_B];
  assign ch_a.pw   = st_q.pw_a;
  assign ch_b.pw   = st_q.pw_b;
  assign ch_a.add  = st_q.add_a;
  assign ch_b.add  = st_q.add_b;

  always_comb
  begin
    run_any  = st_q.ctrl[CTRL_RUN_A] || st_q.ctrl[CTRL_RUN_B];
    // A period field lowered mid-period ends the current period at the end of the current step
    fund_end = (st_q.unit == UNITS_PER_STEP)
               && (st_q.step >= st_q.ctrl[7:CTRL_PER_LSB]);
    all_end  = run_any && fund_end && (st_q.idx == STEPS_PER_ALL);
    access   = psel && penable && st_q.ready;
    wr       = access && pwrite;
    rd       = access && !pwrite;
    hit      = 1'b1;
    rval     = 8'h00;
    if (paddr == dpap_addr(IDX_ROUTE))
      rval = ROUTE_ONES | {3'b000, st_q.route[2], 2'b00, st_q.route[1:0]};
    else if (paddr == dpap_addr(IDX_ADD_A))
      rval = {st_q.add_a, ADD_FILL};
    else if (paddr == dpap_addr(IDX_PW_A))
      rval = st_q.pw_a;
    else if (paddr == dpap_addr(IDX_ADD_B))
      rval = {st_q.add_b, ADD_FILL};
    else if (paddr == dpap_addr(IDX_PW_B))
      rval = st_q.pw_b;
    else if (paddr == dpap_addr(IDX_CTRL))
      rval = st_q.ctrl;
    else if (paddr == dpap_addr(IDX_IRQ_STS))
      rval = {7'h00, st_q.sts};
    else if (paddr == dpap_addr(IDX_IRQ_MSK))
      rval = {7'h00, st_q.msk};
    else
      hit = 1'b0;

    st_d = st_q;
    // One wait state so read data leave a flip-flop
    st_d.ready = psel && penable && !st_q.ready;
    if (psel && penable && !st_q.ready)
    begin
      st_d.rdata  = pwrite ? 32'h0000_0000 : {24'h000000, rval};
      st_d.slverr = !hit;
    end
    else if (!psel)
    begin
      st_d.slverr = 1'b0;
    end

    if (wr)
    begin
      if (paddr == dpap_addr(IDX_ROUTE))
        st_d.route = {pwdata[ROUTE_MON_BIT], pwdata[ROUTE_FIX_BIT],
                      pwdata[ROUTE_SEL_BIT]};
      else if (paddr == dpap_addr(IDX_ADD_A))
        st_d.add_a = pwdata[ADD_LSB +: 4];
      else if (paddr == dpap_addr(IDX_PW_A))
        st_d.pw_a = pwdata[7:0];
      else if (paddr == dpap_addr(IDX_ADD_B))
        st_d.add_b = pwdata[ADD_LSB +: 4];
      else if (paddr == dpap_addr(IDX_PW_B))
        st_d.pw_b = pwdata[7:0];
      else if (paddr == dpap_addr(IDX_CTRL))
        // Flag only clears by writing zero; writing one keeps it
        st_d.ctrl = {pwdata[7:2],
                     pwdata[CTRL_OV] & st_q.ctrl[CTRL_OV],
                     pwdata[CTRL_IE]};
      else if (paddr == dpap_addr(IDX_IRQ_MSK))
        st_d.msk = pwdata[0];
    end
    if (rd && paddr == dpap_addr(IDX_IRQ_STS))
      st_d.sts = 1'b0;

    // Timebase stops and rewinds while both channels are stopped
    if (!run_any)
    begin
      st_d.unit = 4'h0;
      st_d.step = 4'h0;
      st_d.idx  = 4'h0;
    end
    else if (fund_end)
    begin
      st_d.unit = 4'h0;
      st_d.step = 4'h0;
      st_d.idx  = st_q.idx + 4'h1;
    end
    else if (st_q.unit == UNITS_PER_STEP)
    begin
      st_d.unit = 4'h0;
      st_d.step = st_q.step + 4'h1;
    end
    else
    begin
      st_d.unit = st_q.unit + 4'h1;
    end

    // Set wins over a clear in the same cycle
    if (all_end)
    begin
      st_d.ctrl[CTRL_OV] = 1'b1;
      st_d.sts = 1'b1;
    end

    st_d.irq = (st_q.ctrl[CTRL_OV] && st_q.ctrl[CTRL_IE])
               || (st_q.sts && st_q.msk);
    if (st_q.route[0])
    begin
      st_d.p2 = {ch_b.wave, ch_a.wave};
      st_d.p3 = 2'b00;
    end
    else
    begin
      st_d.p2 = 2'b00;
      st_d.p3 = {ch_b.wave, ch_a.wave};
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q       <= '0;
      st_q.route <= ROUTE_RESET;
      st_q.add_a <= ADD_RESET;
      st_q.pw_a  <= PW_RESET;
      st_q.add_b <= ADD_RESET;
      st_q.pw_b  <= PW_RESET;
      st_q.ctrl  <= CTRL_RESET;
      st_q.irq   <= IRQ_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign prdata    = st_q.rdata;
  assign pready    = st_q.ready;
  assign pslverr   = st_q.slverr;
  assign irq       = st_q.irq;
  assign port2_pwm = st_q.p2;
  assign port3_pwm = st_q.p3;

  AST_OV_SET: assert property (@(posedge mclk) disable iff (!rst_n)
    all_end |=> st_q.ctrl[CTRL_OV])
    else $error("overflow flag not set at end of overall period");
  AST_IRQ_REQ: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q.ctrl[CTRL_OV] && st_q.ctrl[CTRL_IE]) |=> irq)
    else $error("interrupt missing with flag and enable set");
  // Checked where the step meets the field; a lowered field may end
  // a period later than that, so the end itself is not the trigger
  AST_FUND_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
    (run_any && st_q.unit == UNITS_PER_STEP
      && st_q.step == st_q.ctrl[7:CTRL_PER_LSB])
      |=> st_q.step == 4'h0 && st_q.unit == 4'h0)
    else $error("fundamental period length wrong");
  AST_OVERALL: assert property (@(posedge mclk) disable iff (!rst_n)
    all_end |=> st_q.idx == 4'h0 && st_q.unit == 4'h0)
    else $error("overall period not sixteen fundamentals");
  AST_LOW_ONES: assert property (@(posedge mclk) disable iff (!rst_n)
    (pready && !pwrite && psel
      && paddr == dpap_addr(IDX_ADD_B)) |-> prdata[3:0] == ADD_FILL)
    else $error("added-pulse low nibble not ones");

  // Pin routing and stop checks
  AST_ROUTE_P2: assert property (@(posedge mclk) disable iff (!rst_n)
    st_q.route[0] |=> port3_pwm == 2'b00)
    else $error("port-3 pair driven while port-2 selected");
  AST_ROUTE_P3: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_q.route[0] |=> port2_pwm == 2'b00)
    else $error("port-2 pair driven while port-3 selected");
  AST_STOP_A: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_q.ctrl[CTRL_RUN_A] |-> ##2 !port2_pwm[0] && !port3_pwm[0])
    else $error("stopped channel a drives high");
  AST_STOP_B: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_q.ctrl[CTRL_RUN_B] |-> ##2 !port2_pwm[1] && !port3_pwm[1])
    else $error("stopped channel b drives high");

  // Flag, interrupt and timebase checks
  AST_STS_SET: assert property (@(posedge mclk)
    disable iff (!rst_n) all_end |=> st_q.sts)
    else $error("status bit not set at end of overall period");
  AST_OV_HOLD: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (st_q.ctrl[CTRL_OV] && !(wr && paddr == dpap_addr(IDX_CTRL)))
      |=> st_q.ctrl[CTRL_OV])
    else $error("overflow flag cleared without a write");
  AST_IRQ_QUIET: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (!(st_q.ctrl[CTRL_OV] && st_q.ctrl[CTRL_IE]) && !(st_q.sts && st_q.msk))
      |=> !irq)
    else $error("interrupt raised with no enabled source");
  AST_REWIND: assert property (@(posedge mclk)
    disable iff (!rst_n)
    !run_any |=> st_q.unit == 4'h0 && st_q.step == 4'h0 && st_q.idx == 4'h0)
    else $error("timebase runs while both channels stopped");
  // Each fundamental period moves the added-pulse index on by one
  AST_IDX_STEP: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (run_any && fund_end) |=> st_q.idx == $past(st_q.idx) + 4'h1)
    else $error("period index skipped");
endmodule

// ==== dpap_load.sv ====
// Integrating load on the four PWM pins of the block
`timescale 1ns/1ps
module dpap_load
(
  // Clock and window control
  input  wire logic             mclk,
  input  wire logic             clr,
  // Pins from the block
  input  wire logic [1:0]       port2_pwm,
  input  wire logic [1:0]       port3_pwm,
  // Integrated results
  output logic      [3:0][15:0] hi_cnt,
  output logic      [15:0]      rise_gap
);
  logic [3:0]  pins;
  logic        rise;
  logic        lvl_q;
  logic [15:0] gap_q;
  assign pins = {port3_pwm, port2_pwm};
  // Only one pair is live at a time, so channel a is watched on both
  assign rise = (pins[0] | pins[2]) & ~lvl_q;
  always_ff @(posedge mclk)
  begin
    lvl_q <= pins[0] | pins[2];
    gap_q <= rise ? 16'h0001 : gap_q + 16'h0001;
    if (rise)
      rise_gap <= gap_q;
    for (int i = 0; i < 4; i++)
      hi_cnt[i] <= clr ? 16'h0000 : hi_cnt[i] + 16'(pins[i]);
  end
endmodule

// ==== dpap_top_bench.sv ====
// Self-checking bench: APB register access and pin-level PWM measurement
`timescale 1ns/1ps
module dpap_top_bench;
  import dpap_pkg::*;
  // Cases packed as period field, width, added field
  localparam logic [15:0] CASES [5] =
    '{16'h0050, 16'h94d0, 16'h1149, 16'hfc8f, 16'h3001};
  logic              mclk;
  logic              rstn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic [1:0]        port2_pwm;
  logic [1:0]        port3_pwm;
  logic              clr;
  logic [3:0][15:0]  hi_cnt;
  logic [15:0]       rise_gap;
  logic [31:0]       rd;
  logic              err;
  logic [3:0]        p;
  logic [3:0]        k;
  logic [3:0]        kb;
  logic [7:0]        w;
  int                ea;
  int                eb;
  int                miscompares;
  int                n_checks;

  always #25 mclk = ~mclk;

  dpap_top i_dpap_top (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .port2_pwm(port2_pwm), .port3_pwm(port3_pwm));
  dpap_load i_dpap_load (.mclk(mclk), .clr(clr), .port2_pwm(port2_pwm),
    .port3_pwm(port3_pwm), .hi_cnt(hi_cnt), .rise_gap(rise_gap));

  task automatic complete_run;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One transfer, then an idle cycle so strobes never flip in one step
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [7:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    // Ready is read at the rising edge, before that edge updates it
    @(posedge mclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        miscompares++;
        complete_run();
      end
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask

  task automatic irq_is(input logic exp);
    @(negedge mclk);
    check({31'h0, irq}, {31'h0, exp});
    @(posedge mclk);
  endtask

  // Window of n edges; ends at a falling edge with counts settled
  task automatic measure(input int n);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  initial
  begin
    mclk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    clr = 1'b0;
    miscompares = 0;
    n_checks = 0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    rdchk(IDX_ROUTE, 32'h000000ec);
    rdchk(IDX_ADD_A, 32'h0000000f);
    rdchk(IDX_PW_A, 32'h00000000);
    rdchk(IDX_ADD_B, 32'h0000000f);
    rdchk(IDX_PW_B, 32'h00000000);
    rdchk(IDX_CTRL, 32'h00000000);
    wr(IDX_ADD_A, 8'ha5);
    rdchk(IDX_ADD_A, 32'h000000af);
    rdchk(16'hfe60, 32'h00000000);
    check({31'h0, err}, 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      {p, w, k} = CASES[i];
      // Inverted field kept at four bits before it is widened
      kb = ~k;
      wr(IDX_PW_A, w);
      wr(IDX_ADD_A, {k, 4'h0});
      wr(IDX_PW_B, w >> 1);
      wr(IDX_ADD_B, {kb, 4'h0});
      wr(IDX_ROUTE, {7'h00, i[0]});
      wr(IDX_CTRL, {p, 4'hc});
      rdchk(IDX_ROUTE, {24'h0, 7'h76, i[0]});
      ea = 16 * int'(w) + int'(k);
      eb = 16 * int'(w >> 1) + int'(kb);
      repeat (20) @(posedge mclk);
      measure(256 * (int'(p) + 1));
      check(32'(hi_cnt[0]), i[0] ? 32'(ea) : 32'h0);
      check(32'(hi_cnt[1]), i[0] ? 32'(eb) : 32'h0);
      check(32'(hi_cnt[2]), i[0] ? 32'h0 : 32'(ea));
      check(32'(hi_cnt[3]), i[0] ? 32'h0 : 32'(eb));
      if (w != 8'h00)
        check(32'(rise_gap), 32'(16 * (int'(p) + 1)));
      @(posedge mclk);
    end
    wr(IDX_CTRL, 8'h00);
    repeat (20) @(posedge mclk);
    measure(256);
    for (int j = 0; j < 4; j++)
      check(32'(hi_cnt[j]), 32'h0);
    @(posedge mclk);
    // Shortest overall period, 256 cycles, keeps the waits short
    wr(IDX_CTRL, 8'h04);
    repeat (300) @(posedge mclk);
    irq_is(1'b0);
    rdchk(IDX_CTRL, 32'h00000006);
    rdchk(IDX_IRQ_STS, 32'h00000001);
    rdchk(IDX_IRQ_STS, 32'h00000000);
    wr(IDX_CTRL, 8'h07);
    irq_is(1'b1);
    wr(IDX_CTRL, 8'h05);
    irq_is(1'b0);
    wr(IDX_CTRL, 8'h04);
    wr(IDX_IRQ_MSK, 8'h01);
    repeat (300) @(posedge mclk);
    irq_is(1'b1);
    rdchk(IDX_IRQ_STS, 32'h00000001);
    irq_is(1'b0);
    complete_run();
  end
endmodule
